// [rtl/ssr_supervisor.sv]
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module ssr_supervisor
#(
   parameter int TICK_SHORT_CYC_P = ssr_pkg::TICK_SHORT_CYC,
   parameter int TICK_LONG_CYC_P  = ssr_pkg::TICK_LONG_CYC
) (
   input  wire logic                  clk_sys_in,
   input  wire logic                  rst_n_in,
   input  wire logic                  ce_in,
   input  wire logic                  programming_support_pin_in,
   input  wire logic                  err_pin_in,
   input  wire logic [ssr_pkg::ADDR_W-1:0] avs_address_in,
   input  wire logic                  avs_read_in,
   input  wire logic                  avs_write_in,
   input  wire logic [31:0]           avs_writedata_in,
   output var  logic [31:0]           avs_readdata_out,
   output var  logic                  avs_waitrequest_out,
   output var  ssr_pkg::ssr_event_t   startup_out,
   output var  logic                  err_monitor_active_out
);
   import ssr_pkg::*;

   // ***********************************************
   // decoding helpers
   // ***********************************************
   function automatic logic cfg_hit(input logic [5:0] a);
      return a < OFF_CFG_END;
   endfunction

   function automatic logic at(input logic [5:0] a, input logic [5:0] off);
      return a == off;
   endfunction

   function automatic logic [31:0] read_word(
      input ssr_state_t s,
      input logic [5:0] a,
      input logic       programming_support_pin
   );
      logic [7:0] v;
      v = 8'h00;
      if (cfg_hit(a)) begin
         v = s.cfg[a[4:2]];
      end else if (at(a, OFF_WIN_STAT)) begin
         v = {2'h0, s.win_first, s.win_open, s.win_err};
      end else if (at(a, OFF_HB_STAT0)) begin
         v = {5'h00, s.hb_late, s.hb_rsp};
      end else if (at(a, OFF_HB_STAT1)) begin
         v = {4'h0, s.hb_err};
      end else if (at(a, OFF_LOCK)) begin
         v = {4'h0, s.lk};
      end else if (at(a, OFF_SUP_STAT)) begin
         v = {3'h0, programming_support_pin, s.err_act, s.ev.cause};
      end
      // unmapped and write-only offsets read as zero
      return {24'h000000, v};
   endfunction

   // ***********************************************
   // bus slave
   // ***********************************************
   ssr_state_t  q;
   ssr_state_t  n;
   logic        req;
   logic        wr;
   logic        tick;
   logic [16:0] tick_lim;

   assign req = avs_read_in | avs_write_in;
   // a request is answered on its second cycle, so writes act once
   assign wr  = avs_write_in & q.ack;
   assign avs_waitrequest_out = req & ~q.ack;
   assign avs_readdata_out    = q.rdata;
   assign startup_out         = q.ev;
   assign err_monitor_active_out = q.err_act;

   // ***********************************************
   // tick prescaler
   // ***********************************************
   // one shared prescaler serves all three timers, so their ticks stay
   // aligned and a retained tick select takes effect at once
   assign tick_lim = q.cfg[CFG_WD0][TICK_SEL_BIT] ?
                     17'(TICK_LONG_CYC_P - 1) : 17'(TICK_SHORT_CYC_P - 1);
   assign tick = (q.prs >= tick_lim);

   // ***********************************************
   // next state
   // ***********************************************
   always_comb begin
      logic       programming_support_pin;
      logic       win_en;
      logic       hb_en;
      logic       win_good;
      logic       win_bad;
      logic       win_fail;
      logic       hb_to;
      logic       hb_fail;
      logic       err_fail;
      logic [9:0] win_lim;
      programming_support_pin      = programming_support_pin_in;
      win_en   = q.cfg[CFG_WD0][WIN_EN_BIT];
      hb_en    = q.cfg[CFG_WD0][HB_EN_BIT];
      win_good = 1'b0;
      win_bad  = 1'b0;
      win_fail = 1'b0;
      hb_to    = 1'b0;
      hb_fail  = 1'b0;
      err_fail = 1'b0;
      win_lim  = 10'h000;
      n = q;
      n.ev.entry = 1'b0;

      n.ack = req & ~q.ack;
      // read data is refreshed by reads only, so a write leaves the
      // last read value standing for the master
      if (avs_read_in & ~q.ack) begin
         n.rdata = read_word(q, avs_address_in, programming_support_pin);
      end

      // protected registers land in a shadow first
      if (wr && cfg_hit(avs_address_in)) begin
         n.shd[avs_address_in[4:2]] = avs_writedata_in[7:0];
      end

      // any wrong key restarts the sequence
      if (wr && at(avs_address_in, OFF_LOCK)) begin
         n.lk = LK_K0;
         unique case (q.lk)
            LK_K0: begin
               if (avs_writedata_in[7:0] == LOCK_KEY[0]) n.lk = LK_K1;
            end
            LK_K1: begin
               if (avs_writedata_in[7:0] == LOCK_KEY[1]) n.lk = LK_K2;
            end
            LK_K2: begin
               if (avs_writedata_in[7:0] == LOCK_KEY[2]) n.lk = LK_K3;
            end
            LK_K3: begin
               if (avs_writedata_in[7:0] == LOCK_KEY[3]) begin
                  n.cfg = q.shd;
               end
            end
            default: n.lk = LK_K0;
         endcase
      end

      n.prs = tick ? 17'h00000 : q.prs + 17'h00001;

      // ***********************************************
      // window watchdog
      // ***********************************************
      if (q.win_first) begin
         win_lim = FIRST_OPEN_TICKS;
      end else if (q.win_open) begin
         win_lim = {2'h0, q.cfg[CFG_WIN1]};
      end else begin
         win_lim = {2'h0, q.cfg[CFG_WIN0]};
      end
      if (win_en) begin
         if (wr && at(avs_address_in, OFF_WIN_SVC)) begin
            win_good = q.win_open;
            win_bad  = ~q.win_open;
         end else if (tick) begin
            n.win_cnt = q.win_cnt + 10'h001;
            if (n.win_cnt >= win_lim) begin
               n.win_cnt = 10'h000;
               if (q.win_open) begin
                  win_bad = 1'b1;
               end else begin
                  n.win_open = 1'b1;
               end
            end
         end
      end
      if (win_good) begin
         n.win_first = 1'b0;
         n.win_open  = 1'b0;
         n.win_cnt   = 10'h000;
         if (q.win_err != 4'h0) n.win_err = q.win_err - 4'h1;
      end
      if (win_bad) begin
         // the long first window stays until a proper service
         n.win_open = q.win_first;
         n.win_cnt  = 10'h000;
         if (q.win_err != 4'hF) n.win_err = q.win_err + 4'h1;
         win_fail = q.win_err >= q.cfg[CFG_WD1][WIN_THR_LSB +: 4];
      end

      // ***********************************************
      // heartbeat watchdog
      // ***********************************************
      // a response written in a tick cycle costs that tick; the period is
      // long against one cycle, so the slip is accepted
      if (hb_en) begin
         if (wr && at(avs_address_in, OFF_HB_RSP)) begin
            n.hb_rsp = q.hb_rsp + 2'h1;
            if (q.hb_rsp == RSP_LAST) begin
               n.hb_cnt  = 8'h00;
               n.hb_late = 1'b0;
               if (q.hb_err != 4'h0) n.hb_err = q.hb_err - 4'h1;
            end
         end else if (tick) begin
            n.hb_cnt = q.hb_cnt + 8'h01;
            if (n.hb_cnt >= q.cfg[CFG_HB]) begin
               hb_to     = 1'b1;
               n.hb_cnt  = 8'h00;
               n.hb_late = 1'b1;
               if (q.hb_err != 4'hF) n.hb_err = q.hb_err + 4'h1;
            end
         end
      end
      if (hb_to) begin
         hb_fail = q.hb_err >= q.cfg[CFG_WD1][HB_THR_LSB +: 4];
      end

      // ***********************************************
      // error pin monitor, pin low means fault
      // ***********************************************
      n.err_prev = err_pin_in;
      if (!q.err_act && (err_pin_in != q.err_prev)) begin
         n.err_act = 1'b1;
      end
      if (!q.cfg[CFG_ERR][ERRM_EN_BIT] || !q.err_act || err_pin_in) begin
         n.err_cnt = 4'h0;
      end else if (tick) begin
         n.err_cnt = q.err_cnt + 4'h1;
         if (n.err_cnt >= q.cfg[CFG_ERR][ERRM_LIM_LSB +: 4]) begin
            err_fail  = 1'b1;
            n.err_cnt = 4'h0;
         end
      end

      // ***********************************************
      // forced startup entry
      // ***********************************************
      // timers keep running through an entry only with the support pin; without it CFG_RST clears all three enables
      if (err_fail | win_fail | hb_fail) begin
         n.ev.entry = 1'b1;
         n.ev.cause = (err_fail ? CAUSE_ERR : 3'h0) |
                      (win_fail ? CAUSE_WIN : 3'h0) |
                      (hb_fail ? CAUSE_HB : 3'h0);
         if (err_fail) begin
            // configs and statuses untouched here
            n.err_act = 1'b0;
         end
         if (programming_support_pin) begin
            if (win_fail) begin
               // heartbeat statuses and configs are kept
               n.win_err   = 4'h0;
               n.win_open  = 1'b1;
               n.win_cnt   = 10'h000;
               n.win_first = 1'b1;
            end
            if (hb_fail) begin
               // window status and configs are kept
               n.hb_err  = 4'h0;
               n.hb_late = 1'b0;
               n.hb_rsp  = q.hb_rsp;
            end
         end else begin
            // without the support pin the configs, lock and all window and heartbeat
            // registers fall back to reset class default; error monitor state is not reset
            n.cfg       = CFG_RST;
            n.shd       = CFG_RST;
            n.lk        = LK_K0;
            n.win_err   = 4'h0;
            n.win_open  = 1'b1;
            n.win_first = 1'b1;
            n.win_cnt   = 10'h000;
            n.hb_err    = 4'h0;
            n.hb_late   = 1'b0;
            n.hb_rsp    = 2'h0;
            n.hb_cnt    = 8'h00;
         end
      end
   end

   // ***********************************************
   // state register
   // ***********************************************
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q <= STATE_RST;
      end else if (ce_in) begin
         q <= n;
      end
   end
endmodule
`default_nettype wire

// [rtl/ssr_pkg.sv]
`default_nettype none
package ssr_pkg;
   // ***********************************************
   // timing
   // ***********************************************
   localparam int CLK_MHZ        = 125;
   localparam int TICK_SHORT_US  = 100;
   localparam int TICK_LONG_US   = 1000;
   localparam int TICK_SHORT_CYC = TICK_SHORT_US * CLK_MHZ;
   localparam int TICK_LONG_CYC  = TICK_LONG_US * CLK_MHZ;
   localparam logic [9:0] FIRST_OPEN_TICKS = 10'h258;
   localparam logic [1:0] RSP_LAST         = 2'h3;
   // ***********************************************
   // register map, byte offsets
   // ***********************************************
   localparam int ADDR_W = 6;
   localparam int CFG_N  = 6;
   localparam logic [2:0] CFG_ERR  = 3'h0;
   localparam logic [2:0] CFG_WD0  = 3'h1;
   localparam logic [2:0] CFG_WD1  = 3'h2;
   localparam logic [2:0] CFG_HB   = 3'h3;
   localparam logic [2:0] CFG_WIN0 = 3'h4;
   localparam logic [2:0] CFG_WIN1 = 3'h5;
   localparam logic [5:0] OFF_CFG_END  = 6'h18;
   localparam logic [5:0] OFF_WIN_STAT = 6'h18;
   localparam logic [5:0] OFF_HB_STAT0 = 6'h1C;
   localparam logic [5:0] OFF_HB_STAT1 = 6'h20;
   localparam logic [5:0] OFF_LOCK     = 6'h24;
   localparam logic [5:0] OFF_WIN_SVC  = 6'h28;
   localparam logic [5:0] OFF_HB_RSP   = 6'h2C;
   localparam logic [5:0] OFF_SUP_STAT = 6'h30;
   // ***********************************************
   // field positions
   // ***********************************************
   localparam int ERRM_EN_BIT  = 0;
   localparam int ERRM_LIM_LSB = 4;
   localparam int TICK_SEL_BIT = 0;
   localparam int WIN_EN_BIT   = 1;
   localparam int HB_EN_BIT    = 2;
   localparam int WIN_THR_LSB  = 0;
   localparam int HB_THR_LSB   = 4;
   // ***********************************************
   // reset values and codes
   // ***********************************************
   localparam logic [5:0][7:0] CFG_RST =
      {8'h0F, 8'h05, 8'h10, 8'h33, 8'h00, 8'h00};
   localparam logic [3:0][7:0] LOCK_KEY =
      {8'h12, 8'h56, 8'hEF, 8'hAB};
   localparam logic [2:0] CAUSE_ERR = 3'h1;
   localparam logic [2:0] CAUSE_WIN = 3'h2;
   localparam logic [2:0] CAUSE_HB  = 3'h4;

   typedef enum logic [3:0] {
      LK_K0 = 4'h1,
      LK_K1 = 4'h2,
      LK_K2 = 4'h4,
      LK_K3 = 4'h8
   } ssr_lock_t;

   typedef struct packed {
      logic            entry;
      logic [2:0]      cause;
   } ssr_event_t;

   typedef struct packed {
      logic            ack;
      logic [31:0]     rdata;
      ssr_lock_t       lk;
      logic [5:0][7:0] cfg;
      logic [5:0][7:0] shd;
      logic [16:0]     prs;
      logic [9:0]      win_cnt;
      logic            win_open;
      logic            win_first;
      logic [3:0]      win_err;
      logic [7:0]      hb_cnt;
      logic [1:0]      hb_rsp;
      logic            hb_late;
      logic [3:0]      hb_err;
      logic            err_act;
      logic            err_prev;
      logic [3:0]      err_cnt;
      ssr_event_t      ev;
   } ssr_state_t;

   localparam ssr_state_t STATE_RST = '{
      ack: 1'b0, rdata: 32'h0, lk: LK_K0, cfg: CFG_RST, shd: CFG_RST,
      prs: 17'h0, win_cnt: 10'h0, win_open: 1'b1, win_first: 1'b1,
      win_err: 4'h0, hb_cnt: 8'h0, hb_rsp: 2'h0, hb_late: 1'b0,
      hb_err: 4'h0, err_act: 1'b1, err_prev: 1'b1, err_cnt: 4'h0,
      ev: '{entry: 1'b0, cause: 3'h0}};
endpackage
`default_nettype wire

// [bench/ssr_supervisor_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// ***************************************
// bus and startup checks
// ***************************************
module ssr_supervisor_monitor
   import ssr_pkg::*;
(
   input wire logic                clk_sys_in,
   input wire logic                rst_n_in,
   input wire logic                ce_in,
   input wire logic                err_pin_in,
   input wire logic                avs_read_in,
   input wire logic                avs_write_in,
   input wire logic [31:0]         avs_readdata_out,
   input wire logic                avs_waitrequest_out,
   input wire ssr_pkg::ssr_event_t startup_out,
   input wire logic                err_monitor_active_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   logic req;
   assign req = avs_read_in | avs_write_in;
   property p_idle; !req |-> !avs_waitrequest_out; endproperty
   a_idle: assert property (p_idle) else $error("wait without request");
   property p_wait; req && avs_waitrequest_out && ce_in |=> !avs_waitrequest_out; endproperty
   a_wait: assert property (p_wait) else $error("answer late");
   property p_again; req && !avs_waitrequest_out && ce_in |=> avs_waitrequest_out || !req;
   endproperty
   a_again: assert property (p_again) else $error("answer too long");
   property p_hold; !avs_read_in |=> $stable(avs_readdata_out); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_pulse; startup_out.entry |=> !startup_out.entry; endproperty
   a_pulse: assert property (p_pulse) else $error("entry too long");
   property p_cause; !startup_out.entry |-> $stable(startup_out.cause); endproperty
   a_cause: assert property (p_cause) else $error("cause moved");
   property p_errfail;
      startup_out.entry && startup_out.cause[0] |-> !$past(err_pin_in) || !$past(err_pin_in, 2);
   endproperty
   a_errfail: assert property (p_errfail) else $error("error entry, pin high");
   property p_wake;
      $rose(err_monitor_active_out) |-> $past(err_pin_in) != $past(err_pin_in, 2)
         || $past(err_pin_in, 2) != $past(err_pin_in, 3);
   endproperty
   a_wake: assert property (p_wake) else $error("monitor woke, no edge");
   property p_drop;
      $fell(err_monitor_active_out) |-> ##[0:2] (startup_out.entry && startup_out.cause[0]);
   endproperty
   a_drop: assert property (p_drop) else $error("monitor idle, no entry");
   c_err: cover property (startup_out.entry && startup_out.cause == CAUSE_ERR);
   c_win: cover property (startup_out.entry && startup_out.cause == CAUSE_WIN);
   c_hb: cover property (startup_out.entry && startup_out.cause == CAUSE_HB);
endmodule
bind ssr_supervisor ssr_supervisor_monitor u_mon (.clk_sys_in(clk_sys_in),
   .rst_n_in(rst_n_in), .ce_in(ce_in), .err_pin_in(err_pin_in), .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out), .startup_out(startup_out),
   .err_monitor_active_out(err_monitor_active_out));
`default_nettype wire

// [bench/ssr_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ***************************************
// controller side of the error pin
// ***************************************
module ssr_ctrl_model (
   input  wire logic clk_sys_in,
   input  wire logic rst_n_in,
   input  wire logic fault_req_in,
   output var  logic err_pin_out
);
   // one cycle of lag, as a real controller reacts from its own clock
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         err_pin_out <= 1'b1;
      end else begin
         err_pin_out <= !fault_req_in;
      end
   end
endmodule
`default_nettype wire

// [bench/supervision_state_retention_test.sv]
`timescale 1ns/1ps
`default_nettype none
module supervision_state_retention_test;
   import ssr_pkg::*;
   logic clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1, sup_pin = 1'b1, fault_req = 1'b0;
   logic rd = 1'b0, wr = 1'b0, waitreq, err_pin, err_act;
   logic [5:0] addr = 6'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [7:0] q;
   ssr_event_t startup;
   int err_count = 0, compares = 0, t0, cyc, i;
   always #4 clk_sys = ~clk_sys;
   ssr_supervisor #(.TICK_SHORT_CYC_P(10), .TICK_LONG_CYC_P(40)) uut (.clk_sys_in(clk_sys),
      .rst_n_in(rst_n), .ce_in(ce), .programming_support_pin_in(sup_pin), .err_pin_in(err_pin),
      .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
      .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .startup_out(startup),
      .err_monitor_active_out(err_act));
   ssr_ctrl_model u_ctrl (.clk_sys_in(clk_sys), .rst_n_in(rst_n), .fault_req_in(fault_req),
      .err_pin_out(err_pin));
   // ***************************************
   // helpers
   // ***************************************
   task automatic fail(input string m);
      err_count++;
      $display("FAIL %0t: %s", $time, m);
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) fail($sformatf("got %h want %h", got, exp));
   endtask
   task automatic rng(input int v, input int lo, input int hi);
      compares++;
      if (v < lo || v > hi) fail($sformatf("span %0d", v));
   endtask
   // request opens one edge after entry so no strobe is assigned twice at an edge
   task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= {24'h0, d};
      // waitrequest is sampled at each rising edge; only the watchdog ends a hang
      do begin
         @(posedge clk_sys);
      end while (waitreq !== 1'b0);
      q = rdata[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      check(q, e);
   endtask
   task automatic lock;
      for (int k = 0; k < 4; k++) bus(1'b1, OFF_LOCK, LOCK_KEY[k]);
   endtask
   task automatic wait_entry(input int max);
      cyc = 0;
      do begin
         @(posedge clk_sys);
         #1;
         cyc++;
      end while (startup.entry !== 1'b1 && cyc < max);
      if (cyc >= max) fail("no entry");
   endtask
   task automatic print_verdict;
      $display("err_count %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #(8 * 30000);
      fail("watchdog");
      print_verdict();
   end
   // ***************************************
   // tests
   // ***************************************
   initial begin
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (i = 0; i < CFG_N; i++) rd_chk(6'(i * 4), CFG_RST[i]);
      rd_chk(OFF_WIN_STAT, 8'h30);
      rd_chk(6'h3C, 8'h00);
      bus(1'b1, 6'h04, 8'h02);
      bus(1'b1, 6'h08, 8'h00);
      rd_chk(6'h04, 8'h00);
      lock();
      rd_chk(6'h04, 8'h02);
      wait_entry(7000);
      rng(cyc, 5980, 6000);
      check({5'h0, startup.cause}, {5'h0, CAUSE_WIN});
      rd_chk(6'h04, 8'h02);
      rd_chk(OFF_WIN_STAT, 8'h30);
      t0 = int'($time);
      wait_entry(7000);
      rng((int'($time) - t0) / 8, 5985, 6015);
      bus(1'b1, OFF_WIN_SVC, 8'h00);
      // after a 20 cycle freeze the next failure must come 185 to 215 cycles after the enable returns
      ce <= 1'b0;
      repeat (20) @(posedge clk_sys);
      ce <= 1'b1;
      wait_entry(400);
      rng(cyc, 185, 215);
      bus(1'b1, 6'h04, 8'h04);
      lock();
      wait_entry(400);
      bus(1'b1, OFF_HB_RSP, 8'h00);
      bus(1'b1, OFF_HB_RSP, 8'h00);
      wait_entry(400);
      check({5'h0, startup.cause}, {5'h0, CAUSE_HB});
      rd_chk(OFF_HB_STAT0, 8'h02);
      rd_chk(OFF_HB_STAT1, 8'h00);
      rd_chk(6'h04, 8'h04);
      bus(1'b1, 6'h00, 8'h21);
      bus(1'b1, 6'h04, 8'h00);
      lock();
      fault_req <= 1'b1;
      wait_entry(200);
      check({5'h0, startup.cause}, {5'h0, CAUSE_ERR});
      rd_chk(6'h00, 8'h21);
      repeat (100) @(posedge clk_sys);
      check({7'h0, err_act}, 8'h00);
      fault_req <= 1'b0;
      repeat (5) @(posedge clk_sys);
      check({7'h0, err_act}, 8'h01);
      sup_pin <= 1'b0;
      fault_req <= 1'b1;
      wait_entry(200);
      rd_chk(6'h00, CFG_RST[0]);
      rd_chk(6'h08, CFG_RST[2]);
      fault_req <= 1'b0;
      print_verdict();
   end
endmodule
`default_nettype wire
